//--- include/i2c_frame_pkg.sv
// Constants, register map and types for the two-wire frame and bus status block
package i2c_frame_pkg;
	// Register byte addresses
	localparam logic [7:0] ADDR_CTRL = 8'h00;
	localparam logic [7:0] ADDR_MODE = 8'h04;
	localparam logic [7:0] ADDR_TIMER = 8'h08;
	localparam logic [7:0] ADDR_STATUS = 8'h0C;
	localparam logic [7:0] ADDR_DATA = 8'h10;
	localparam logic [7:0] ADDR_IRQ_STAT = 8'h14;
	localparam logic [7:0] ADDR_IRQ_CLR = 8'h18;
	localparam logic [7:0] ADDR_IRQ_EN = 8'h1C;
	// Control, timer and mode register fields
	localparam int CTRL_EN = 7;
	localparam int CTRL_MST = 5;
	localparam int CTRL_ACK = 3;
	localparam int CTRL_RATE_LSB = 0;
	localparam int TIMER_EXT = 0;
	localparam int MODE_BC_LSB = 0;
	// Bus status register fields
	localparam int ST_BUSY = 7;
	localparam int ST_TRANSFER_INTERRUPT_FLAG = 6;
	localparam int ST_INHIBIT = 5;
	localparam int ST_RSVD = 4;
	localparam int ST_AL = 3;
	localparam int ST_AAS = 2;
	localparam int ST_ADZ = 1;
	localparam int ST_HANDSHAKE_BIT_VALUE = 0;
	// Interrupt status bits
	localparam int IRQ_DONE = 0;
	localparam int IRQ_AL = 1;
	localparam int IRQ_START = 2;
	localparam int IRQ_STOP = 3;
	localparam int IRQ_W = 4;
	// Reset values and full frame bit count
	localparam logic [7:0] CTRL_RST = 8'h00;
	localparam logic [2:0] MODE_RST = 3'h0;
	localparam logic [7:0] STATUS_RST = 8'h30;
	localparam logic [3:0] FULL_FRAME = 4'h8;
	// Serial clock divisors, normal and extended range
	localparam logic [8:0] DIV_NORM [8] = '{9'h01C, 9'h028, 9'h030, 9'h040,
		9'h050, 9'h064, 9'h070, 9'h080};
	localparam logic [8:0] DIV_EXT [8] = '{9'h038, 9'h050, 9'h060, 9'h080,
		9'h0A0, 9'h0C8, 9'h0E0, 9'h100};
	typedef enum logic [2:0] {
		ST_IDLE = 3'h0,
		ST_STA = 3'h1,
		ST_HOLD = 3'h3,
		ST_LO = 3'h2,
		ST_HI = 3'h6,
		ST_STO1 = 3'h7,
		ST_STO2 = 3'h5,
		ST_RS = 3'h4
	} master_state_t;
endpackage

//--- include/rate_if.sv
// Rate select and half-period tick between controller and divider
`timescale 1ns/1ps
interface rate_if;
	logic [2:0] sel;
	logic ext;
	logic run;
	logic tick;
	modport ctrl (output sel, output ext, output run, input tick);
	modport gen (input sel, input ext, input run, output tick);
endinterface

//--- logic/rate_divider.sv
// Serial clock divider giving one tick per half period of the serial clock
`timescale 1ns/1ps
module rate_divider
	import i2c_frame_pkg::*;
(
	input wire logic ref_clk, // Peripheral clock
	input wire logic resetn, // Async reset, active low
	rate_if.gen rate // Rate select in, tick out
);
	logic [7:0] cnt_r;
	logic [7:0] cnt_nxt;
	logic tick_r;
	logic tick_nxt;
	logic [7:0] half;
	logic [7:0] gap_r;
	logic gap_ok_r;

	always_comb begin
		// one tick per half divisor
		// All divisors are even, so half a period is exact
		half = rate.ext ? DIV_EXT[rate.sel][8:1] : DIV_NORM[rate.sel][8:1];
		cnt_nxt = cnt_r + 8'h01;
		tick_nxt = 1'b0;
		if (!rate.run) begin
			cnt_nxt = 8'h00;
		end else if (cnt_r >= half - 8'h01) begin
			cnt_nxt = 8'h00;
			tick_nxt = 1'b1;
		end
	end

	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			cnt_r <= 8'h00;
			tick_r <= 1'b0;
		end else begin
			cnt_r <= cnt_nxt;
			tick_r <= tick_nxt;
		end
	end

	assign rate.tick = tick_r;

	// Checker helper: cycles since last tick, valid while the rate holds
	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			gap_r <= 8'h00;
			gap_ok_r <= 1'b0;
		end else begin
			gap_r <= tick_r ? 8'h00 : gap_r + 8'h01;
			if (!rate.run || !$stable(rate.sel) || !$stable(rate.ext)) begin
				gap_ok_r <= 1'b0;
			end else if (tick_r) begin
				gap_ok_r <= 1'b1;
			end
		end
	end

	AST_DIV_NORM: assert property (@(posedge ref_clk) disable iff (!resetn)
		tick_r && gap_ok_r && !rate.ext && $stable(rate.sel) && $stable(rate.ext)
		|-> gap_r == DIV_NORM[rate.sel][8:1] - 8'h01)
		else $error("Normal range half period wrong");

	AST_DIV_EXT: assert property (@(posedge ref_clk) disable iff (!resetn)
		tick_r && gap_ok_r && rate.ext && $stable(rate.sel) && $stable(rate.ext)
		|-> gap_r == DIV_EXT[rate.sel][8:1] - 8'h01)
		else $error("Extended range half period wrong");
endmodule

//--- logic/i2c_frame_ctrl.sv
// Two-wire master frame engine, serial clock select and bus status register
`timescale 1ns/1ps
module i2c_frame_ctrl
	import i2c_frame_pkg::*;
(
	input wire logic ref_clk, // Peripheral clock, 200 MHz
	input wire logic resetn, // Async reset, active low
	input wire logic [7:0] addr, // Register byte address
	input wire logic [7:0] wdata, // Register write data
	input wire logic wr_stb, // Write strobe
	input wire logic rd_stb, // Read strobe
	output logic [7:0] rdata, // Read data, cycle after strobe
	input wire logic scl_i, // Clock line level
	output logic scl_o, // Clock line drive value
	output logic scl_oe, // Pull clock line low
	input wire logic sda_i, // Data line level
	output logic sda_o, // Data line drive value
	output logic sda_oe, // Pull data line low
	input wire logic addr_match_evt, // Own address matched pulse
	input wire logic bcast_evt, // Broadcast call seen pulse
	output logic irq // Level interrupt request
);
	import i2c_frame_pkg::*;

	rate_if rate ();

	logic scl_m_r, scl_s_r, sda_m_r, sda_s_r, sda_p_r;
	logic start_det, stop_det;
	master_state_t state_r, state_nxt;
	logic [7:0] ctrl_r, ctrl_nxt;
	logic [2:0] mode_r, mode_nxt;
	logic ext_r, ext_nxt;
	logic occupied_r, occupied_nxt;
	logic transfer_interrupt_flag_r, transfer_interrupt_flag_nxt;
	logic al_r, al_nxt;
	logic aas_r, aas_nxt;
	logic adz_r, adz_nxt;
	logic handshake_bit_value_r, handshake_bit_value_nxt;
	logic [7:0] tx_r, tx_nxt;
	logic [7:0] rx_r, rx_nxt;
	logic go_r, go_nxt;
	logic start_req_r, start_req_nxt;
	logic stop_req_r, stop_req_nxt;
	logic [3:0] cnt_r, cnt_nxt;
	logic scl_low_r, scl_low_nxt;
	logic sda_low_r, sda_low_nxt;
	logic [IRQ_W-1:0] irq_stat_r, irq_stat_nxt;
	logic [IRQ_W-1:0] irq_en_r, irq_en_nxt;
	logic [IRQ_W-1:0] ev;
	logic [7:0] rdata_r, rdata_nxt;
	logic enable, master, ack_mode, last, lost, wr_status;
	logic [3:0] fbits, total;

	// Pin synchronisers
	// two flops first
	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			scl_m_r <= 1'b1;
			scl_s_r <= 1'b1;
			sda_m_r <= 1'b1;
			sda_s_r <= 1'b1;
			sda_p_r <= 1'b1;
		end else begin
			scl_m_r <= scl_i;
			scl_s_r <= scl_m_r;
			sda_m_r <= sda_i;
			sda_s_r <= sda_m_r;
			sda_p_r <= sda_s_r;
		end
	end

	assign start_det = scl_s_r && sda_p_r && !sda_s_r;
	assign stop_det = scl_s_r && !sda_p_r && sda_s_r;

	assign enable = ctrl_r[CTRL_EN];
	assign master = ctrl_r[CTRL_MST];
	// Zero in the mode bit selects acknowledge framing
	assign ack_mode = !ctrl_r[CTRL_ACK];
	// code zero is a full byte
	assign fbits = (mode_r == 3'h0) ? FULL_FRAME : {1'b0, mode_r};
	// one extra bit in acknowledge mode
	// no extra bit in serial mode
	assign total = fbits + {3'h0, ack_mode};
	assign last = (cnt_r == total - 4'h1);
	// Released data bit read back low means another master won
	assign lost = (cnt_r < fbits) && !sda_low_r && !sda_s_r;
	assign wr_status = wr_stb && (addr == ADDR_STATUS);

	assign rate.sel = ctrl_r[CTRL_RATE_LSB +: 3];
	assign rate.ext = ext_r;
	assign rate.run = enable && master;

	rate_divider u_div (
		.ref_clk(ref_clk),
		.resetn(resetn),
		.rate(rate)
	);

	always_comb begin
		state_nxt = state_r;
		ctrl_nxt = ctrl_r;
		mode_nxt = mode_r;
		ext_nxt = ext_r;
		occupied_nxt = occupied_r;
		transfer_interrupt_flag_nxt = transfer_interrupt_flag_r;
		al_nxt = al_r;
		aas_nxt = aas_r;
		adz_nxt = adz_r;
		handshake_bit_value_nxt = handshake_bit_value_r;
		tx_nxt = tx_r;
		rx_nxt = rx_r;
		go_nxt = go_r;
		start_req_nxt = start_req_r;
		stop_req_nxt = stop_req_r;
		cnt_nxt = cnt_r;
		scl_low_nxt = scl_low_r;
		sda_low_nxt = sda_low_r;
		irq_stat_nxt = irq_stat_r;
		irq_en_nxt = irq_en_r;
		ev = '0;
		if (wr_stb) begin
			if (addr == ADDR_CTRL) begin
				ctrl_nxt = wdata;
			end else if (addr == ADDR_MODE) begin
				mode_nxt = wdata[MODE_BC_LSB +: 3];
			end else if (addr == ADDR_TIMER) begin
				ext_nxt = wdata[TIMER_EXT];
			end else if (addr == ADDR_DATA) begin
				tx_nxt = wdata;
				go_nxt = 1'b1;
			end else if (addr == ADDR_IRQ_CLR) begin
				irq_stat_nxt = irq_stat_r & ~wdata[IRQ_W-1:0];
			end else if (addr == ADDR_IRQ_EN) begin
				irq_en_nxt = wdata[IRQ_W-1:0];
			end else if (addr == ADDR_STATUS) begin
				transfer_interrupt_flag_nxt = transfer_interrupt_flag_r && wdata[ST_TRANSFER_INTERRUPT_FLAG];
				al_nxt = al_r && wdata[ST_AL];
				aas_nxt = aas_r && wdata[ST_AAS];
				adz_nxt = adz_r && wdata[ST_ADZ];
				handshake_bit_value_nxt = wdata[ST_HANDSHAKE_BIT_VALUE];
				if (master && enable && !wdata[ST_INHIBIT]) begin
					if (wdata[ST_BUSY]) begin
						start_req_nxt = 1'b1;
					end else begin
						stop_req_nxt = 1'b1;
					end
				end
			end
		end
		if (start_det) begin
			occupied_nxt = 1'b1;
			ev[IRQ_START] = 1'b1;
		end
		if (stop_det) begin
			occupied_nxt = 1'b0;
			ev[IRQ_STOP] = 1'b1;
		end
		if (rate.tick) begin
			case (state_r)
				ST_IDLE: begin
					stop_req_nxt = 1'b0;
					// Wait for a free bus before claiming it
					if (start_req_r && !occupied_r) begin
						sda_low_nxt = 1'b1;
						start_req_nxt = 1'b0;
						state_nxt = ST_STA;
					end
				end
				ST_STA: begin
					scl_low_nxt = 1'b1;
					state_nxt = ST_HOLD;
				end
				ST_HOLD: begin
					if (start_req_r) begin
						scl_low_nxt = 1'b0;
						sda_low_nxt = 1'b0;
						start_req_nxt = 1'b0;
						state_nxt = ST_RS;
					end else if (stop_req_r) begin
						sda_low_nxt = 1'b1;
						stop_req_nxt = 1'b0;
						state_nxt = ST_STO1;
					end else if (go_r) begin
						sda_low_nxt = !tx_r[7];
						go_nxt = 1'b0;
						cnt_nxt = 4'h0;
						state_nxt = ST_LO;
					end
				end
				ST_LO: begin
					scl_low_nxt = 1'b0;
					state_nxt = ST_HI;
				end
				ST_HI: begin
					if (cnt_r < fbits) begin
						rx_nxt = {rx_r[6:0], sda_s_r};
					end else begin
						handshake_bit_value_nxt = sda_s_r;
					end
					if (lost) begin
						al_nxt = 1'b1;
						ev[IRQ_AL] = 1'b1;
						ctrl_nxt[CTRL_MST] = 1'b0;
						sda_low_nxt = 1'b0;
						go_nxt = 1'b0;
						state_nxt = ST_IDLE;
					end else if (last) begin
						ev[IRQ_DONE] = 1'b1;
						scl_low_nxt = 1'b1;
						sda_low_nxt = 1'b0;
						cnt_nxt = 4'h0;
						state_nxt = ST_HOLD;
					end else begin
						cnt_nxt = cnt_r + 4'h1;
						tx_nxt = {tx_r[6:0], 1'b0};
						scl_low_nxt = 1'b1;
						// Ack slot leaves the line free for the receiver
						sda_low_nxt = (cnt_r + 4'h1 < fbits) && !tx_r[6];
						state_nxt = ST_LO;
					end
				end
				ST_STO1: begin
					scl_low_nxt = 1'b0;
					state_nxt = ST_STO2;
				end
				ST_STO2: begin
					sda_low_nxt = 1'b0;
					state_nxt = ST_IDLE;
				end
				ST_RS: begin
					sda_low_nxt = 1'b1;
					state_nxt = ST_STA;
				end
				default: begin
					state_nxt = ST_IDLE;
				end
			endcase
		end
		if (!enable) begin
			state_nxt = ST_IDLE;
			scl_low_nxt = 1'b0;
			sda_low_nxt = 1'b0;
			start_req_nxt = 1'b0;
			stop_req_nxt = 1'b0;
			go_nxt = 1'b0;
		end
		// Hardware sets win over a clearing write
		if (ev[IRQ_DONE] || ev[IRQ_AL] || addr_match_evt || bcast_evt) begin
			transfer_interrupt_flag_nxt = 1'b1;
		end
		if (addr_match_evt) begin
			aas_nxt = 1'b1;
		end
		if (bcast_evt) begin
			adz_nxt = 1'b1;
		end
		irq_stat_nxt = irq_stat_nxt | ev;
	end

	always_comb begin
		rdata_nxt = 8'h00;
		if (rd_stb) begin
			if (addr == ADDR_CTRL) begin
				rdata_nxt = ctrl_r;
			end else if (addr == ADDR_MODE) begin
				rdata_nxt = {5'h00, mode_r};
			end else if (addr == ADDR_TIMER) begin
				rdata_nxt = {7'h00, ext_r};
			end else if (addr == ADDR_STATUS) begin
				// Inhibit and reserved bits always read as one
				rdata_nxt = {occupied_r, transfer_interrupt_flag_r, STATUS_RST[ST_INHIBIT:ST_RSVD],
					al_r, aas_r, adz_r, handshake_bit_value_r};
			end else if (addr == ADDR_DATA) begin
				rdata_nxt = rx_r;
			end else if (addr == ADDR_IRQ_STAT) begin
				rdata_nxt = {4'h0, irq_stat_r};
			end else if (addr == ADDR_IRQ_EN) begin
				rdata_nxt = {4'h0, irq_en_r};
			end
		end
	end

	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			state_r <= ST_IDLE;
			ctrl_r <= CTRL_RST;
			mode_r <= MODE_RST;
			ext_r <= 1'b0;
			occupied_r <= STATUS_RST[ST_BUSY];
			transfer_interrupt_flag_r <= STATUS_RST[ST_TRANSFER_INTERRUPT_FLAG];
			al_r <= STATUS_RST[ST_AL];
			aas_r <= STATUS_RST[ST_AAS];
			adz_r <= STATUS_RST[ST_ADZ];
			handshake_bit_value_r <= STATUS_RST[ST_HANDSHAKE_BIT_VALUE];
			tx_r <= 8'h00;
			rx_r <= 8'h00;
			go_r <= 1'b0;
			start_req_r <= 1'b0;
			stop_req_r <= 1'b0;
			cnt_r <= 4'h0;
			scl_low_r <= 1'b0;
			sda_low_r <= 1'b0;
			irq_stat_r <= '0;
			irq_en_r <= '0;
			rdata_r <= 8'h00;
		end else begin
			state_r <= state_nxt;
			ctrl_r <= ctrl_nxt;
			mode_r <= mode_nxt;
			ext_r <= ext_nxt;
			occupied_r <= occupied_nxt;
			transfer_interrupt_flag_r <= transfer_interrupt_flag_nxt;
			al_r <= al_nxt;
			aas_r <= aas_nxt;
			adz_r <= adz_nxt;
			handshake_bit_value_r <= handshake_bit_value_nxt;
			tx_r <= tx_nxt;
			rx_r <= rx_nxt;
			go_r <= go_nxt;
			start_req_r <= start_req_nxt;
			stop_req_r <= stop_req_nxt;
			cnt_r <= cnt_nxt;
			scl_low_r <= scl_low_nxt;
			sda_low_r <= sda_low_nxt;
			irq_stat_r <= irq_stat_nxt;
			irq_en_r <= irq_en_nxt;
			rdata_r <= rdata_nxt;
		end
	end

	// Open drain: only ever pull low
	assign scl_o = 1'b0;
	assign sda_o = 1'b0;
	assign scl_oe = scl_low_r;
	assign sda_oe = sda_low_r;
	assign rdata = rdata_r;
	assign irq = |(irq_stat_r & irq_en_r);

	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!resetn);

	AST_START_BUSY: assert property (start_det |=> occupied_r)
		else $error("Start did not set busy");
	AST_STOP_FREE: assert property (stop_det |=> !occupied_r)
		else $error("Stop did not clear busy");
	AST_ACK_FRAME: assert property (ev[IRQ_DONE] && ack_mode |-> cnt_r == fbits)
		else $error("Acknowledge frame length wrong");
	AST_SERIAL_FRAME: assert property (
		ev[IRQ_DONE] && !ack_mode |-> cnt_r == fbits - 4'h1 && sda_oe == $past(sda_oe))
		else $error("Serial frame length wrong");
	AST_FLAG_CLEAR: assert property (
		wr_status && !wdata[ST_AL] && !ev[IRQ_AL] |=> !al_r)
		else $error("Arbitration flag not cleared by zero");
	AST_SLAVE_IGNORE: assert property (
		wr_status && !master && !start_req_r && !stop_req_r |=> !start_req_r && !stop_req_r)
		else $error("Slave mode took a condition request");
	AST_START_GEN: assert property (
		enable && state_r == ST_IDLE && start_req_r && rate.tick && !occupied_r
		|=> sda_oe && !scl_oe ##[1:300] scl_oe && sda_oe)
		else $error("Start condition not driven");
	AST_RESTART: assert property (
		enable && state_r == ST_HOLD && start_req_r && rate.tick
		|=> !sda_oe && !scl_oe && state_r == ST_RS)
		else $error("Repeated start not begun");
	AST_STOP_GEN: assert property (
		enable && state_r == ST_STO1 && rate.tick |=> sda_oe && !scl_oe ##[1:300] !sda_oe)
		else $error("Stop condition not driven");

	COV_START: cover property (start_det);
	COV_FRAME: cover property (ev[IRQ_DONE] && ack_mode);
	COV_LOST: cover property (ev[IRQ_AL]);
	COV_STOP: cover property (state_r == ST_STO2 ##[1:300] stop_det);
endmodule

//--- tb/bus_partner.sv
// Open-drain two-wire bus with pull-ups and a second party on it
`timescale 1ns/1ps
module bus_partner (
	input wire logic ref_clk, // Peripheral clock
	input wire logic scl_oe, // Design pulls clock low
	input wire logic sda_oe, // Design pulls data low
	input wire logic p_scl, // Other party pulls clock low
	input wire logic p_sda, // Other party pulls data low
	input wire logic clr, // Clear rise counters
	output logic scl, // Resolved clock line
	output logic sda, // Resolved data line
	output int rises = 0, // Clock rises since clear
	output int starts = 0, // Start conditions seen
	output int period = 0, // Cycles between last two rises
	output int bits = 0 // Data line shifted in at each rise
);
	int cyc = 0;
	int last = 0;
	logic scl_q;
	logic sda_q;
	// Released lines float high through the pull-ups
	assign scl = ~(scl_oe | p_scl);
	assign sda = ~(sda_oe | p_sda);
	always @(posedge ref_clk) begin
		cyc <= cyc + 1;
		scl_q <= scl;
		sda_q <= sda;
		if (clr) begin
			rises <= 0;
			bits <= 0;
		end else if (scl && !scl_q) begin
			rises <= rises + 1;
			bits <= (bits << 1) | int'(sda);
			period <= cyc - last;
			last <= cyc;
		end
		if (scl && scl_q && sda_q && !sda) begin
			starts <= starts + 1;
		end
	end
endmodule

//--- tb/i2c_frame_clock_and_bus_status_test.sv
// Self-checking bench for the frame engine and bus status register
`timescale 1ns/1ps
module i2c_frame_clock_and_bus_status_test;
	import i2c_frame_pkg::*;
	logic ref_clk = 1'h0;
	logic resetn = 1'h0;
	logic wr_stb = 1'h0;
	logic rd_stb = 1'h0;
	logic [7:0] addr = 8'h00;
	logic [7:0] wdata = 8'h00;
	logic [7:0] rdata;
	logic scl, sda, scl_oe, sda_oe, irq;
	logic scl_o_w, sda_o_w;
	logic p_scl = 1'h0;
	logic p_sda = 1'h0;
	logic clr = 1'h0;
	logic am_evt = 1'h0;
	logic bc_evt = 1'h0;
	logic [7:0] v, d;
	logic [31:0] r;
	int rises, starts, period, bits, n, handshake_bit_value, st0, k, m_busy;
	int miscompares = 0;
	int cmp_count = 0;
	int seed = 32'hBE4B9C63;
	int dn [8] = '{28, 40, 48, 64, 80, 100, 112, 128};

	i2c_frame_ctrl DUT (.ref_clk(ref_clk), .resetn(resetn), .addr(addr), .wdata(wdata),
		.wr_stb(wr_stb), .rd_stb(rd_stb), .rdata(rdata), .scl_i(scl), .scl_o(scl_o_w),
		.scl_oe(scl_oe), .sda_i(sda), .sda_o(sda_o_w), .sda_oe(sda_oe),
		.addr_match_evt(am_evt), .bcast_evt(bc_evt), .irq(irq));
	bus_partner bus (.ref_clk(ref_clk), .scl_oe(scl_oe), .sda_oe(sda_oe), .p_scl(p_scl),
		.p_sda(p_sda), .clr(clr), .scl(scl), .sda(sda), .rises(rises), .starts(starts),
		.period(period), .bits(bits));

	initial begin
		forever #2.5 ref_clk = ~ref_clk;
	end

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp) begin
			miscompares++;
			$display("mismatch at %0t: got %0h expected %0h", $time, got, exp);
		end
	endtask
	task automatic step();
		@(posedge ref_clk);
		#1;
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] q);
		@(posedge ref_clk);
		addr <= a;
		wdata <= q;
		wr_stb <= 1'h1;
		@(posedge ref_clk);
		wr_stb <= 1'h0;
	endtask
	task automatic rd(input logic [7:0] a, output logic [7:0] q);
		@(posedge ref_clk);
		addr <= a;
		rd_stb <= 1'h1;
		@(posedge ref_clk);
		rd_stb <= 1'h0;
		#1;
		q = rdata;
	endtask
	task automatic results();
		if (miscompares == 0 && cmp_count > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask

	initial begin
		#450000;
		miscompares++;
		results();
	end

	initial begin
		m_busy = 0;
		repeat (2) @(posedge ref_clk);
		resetn <= 1'h1;
		rd(ADDR_STATUS, v);
		chk(v, 8'h30);
		step();
		chk(rdata, 8'h00);
		chk({scl_o_w, sda_o_w}, 2'h0);
		rd(8'h3C, v);
		chk(v, 8'h00);
		wr(ADDR_CTRL, 8'h80);
		// Another master seizes the bus
		@(posedge ref_clk);
		p_sda <= 1'h1;
		m_busy = 1;
		repeat (6) step();
		rd(ADDR_STATUS, v);
		chk(v[7], m_busy);
		rd(ADDR_IRQ_STAT, v);
		chk(v, 8'h04);
		chk(irq, 1'h0);
		wr(ADDR_IRQ_EN, 8'h04);
		step();
		chk(irq, 1'h1);
		wr(ADDR_IRQ_CLR, 8'h04);
		step();
		chk(irq, 1'h0);
		@(posedge ref_clk);
		p_sda <= 1'h0;
		m_busy = 0;
		repeat (6) step();
		rd(ADDR_STATUS, v);
		chk(v[7], m_busy);
		// Slave mode must not issue a start
		wr(ADDR_STATUS, 8'h80);
		repeat (50) step();
		chk(sda_oe, 1'h0);
		rd(ADDR_STATUS, v);
		chk(v, 8'h30);
		@(posedge ref_clk);
		am_evt <= 1'h1;
		bc_evt <= 1'h1;
		@(posedge ref_clk);
		am_evt <= 1'h0;
		bc_evt <= 1'h0;
		wr(ADDR_STATUS, 8'hFF);
		rd(ADDR_STATUS, v);
		chk(v, 8'h77);
		wr(ADDR_STATUS, 8'h20);
		rd(ADDR_STATUS, v);
		chk(v, 8'h30);
		wr(ADDR_IRQ_EN, 8'h01);
		for (int i = 0; i < 16; i++) begin
			r = $random(seed);
			d = r[15:8];
			n = (r[2:0] == 3'h0) ? 8 : int'(r[2:0]);
			if (r[3] && n == 1) begin
				n = 2;
			end
			handshake_bit_value = r[3] ? 0 : 1;
			wr(ADDR_TIMER, {7'h00, i[3]});
			wr(ADDR_MODE, {5'h00, n[2:0]});
			wr(ADDR_CTRL, {4'hA, r[3], i[2:0]});
			st0 = starts;
			wr(ADDR_STATUS, 8'h80);
			m_busy = 1;
			for (k = 0; k < 3000 && scl_oe !== 1'h1; k++) step();
			chk(starts, st0 + 1);
			@(posedge ref_clk);
			clr <= 1'h1;
			@(posedge ref_clk);
			clr <= 1'h0;
			wr(ADDR_DATA, d);
			for (k = 0; k < 8000 && irq !== 1'h1; k++) step();
			chk(irq, 1'h1);
			chk(rises, n + handshake_bit_value);
			chk(bits, (((d >> (8 - n)) << handshake_bit_value) | handshake_bit_value));
			chk(period, dn[i[2:0]] << i[3]);
			rd(ADDR_DATA, v);
			chk(v & 8'((1 << n) - 1), d >> (8 - n));
			rd(ADDR_STATUS, v);
			chk(v, {m_busy[0], 6'h38, handshake_bit_value[0]});
			wr(ADDR_IRQ_CLR, 8'h01);
			wr(ADDR_STATUS, 8'h20);
			rd(ADDR_STATUS, v);
			chk(v[7:1], 7'h58);
			chk(irq, 1'h0);
			st0 = starts;
			wr(ADDR_STATUS, 8'h80);
			for (k = 0; k < 3000 && starts == st0; k++) step();
			chk(starts, st0 + 1);
			wr(ADDR_STATUS, 8'h00);
			m_busy = 0;
			for (k = 0; k < 3000 && (scl_oe | sda_oe) !== 1'h0; k++) step();
			repeat (6) step();
			rd(ADDR_STATUS, v);
			chk(v[7], m_busy);
			chk({scl, sda}, 2'h3);
		end
		// Another master holds SDA low through our first bit
		wr(ADDR_IRQ_EN, 8'h02);
		wr(ADDR_STATUS, 8'h80);
		for (k = 0; k < 3000 && scl_oe !== 1'h1; k++) step();
		@(posedge ref_clk);
		p_sda <= 1'h1;
		wr(ADDR_DATA, 8'hFF);
		for (k = 0; k < 3000 && irq !== 1'h1; k++) step();
		chk(irq, 1'h1);
		chk({scl_oe, sda_oe}, 2'h0);
		rd(ADDR_STATUS, v);
		chk(v, 8'hF8);
		wr(ADDR_STATUS, 8'hF6);
		rd(ADDR_STATUS, v);
		chk(v, 8'hF0);
		@(posedge ref_clk);
		p_sda <= 1'h0;
		repeat (6) step();
		rd(ADDR_STATUS, v);
		chk(v, 8'h70);
		results();
	end
endmodule
